// ---- vsm_vector_and_stack_map.sv ----
// Notes on behaviour
// [RULE1] push decrements stack pointer, pull increments it
// [RULE2] interrupt entry stacks exactly five bytes
// [RULE3] upper index register never stacked
// [RULE4] subroutine call stacks two return bytes
// [RULE5] stack pointer resets to 0x00FF
// [RULE6] stack pointer is sixteen bits wide
// [RULE7] RAM 0x0060 to 0x011F or 0x015F
// [RULE8] page zero holds 160 RAM bytes
// [RULE9] serial comm vectors at 0xFFD2, D4, D6
// [RULE10] timer B and converter vector addresses
// [RULE11] timer A vector addresses
// [RULE12] motor pwm and fault vector addresses
// [RULE13] clock, external, software, reset vectors
// [RULE14] 0xFFFF reads vector, write clears watchdog
// [RULE15] monitor ROM range reserved per variant
// [RULE16] vector high byte even, low byte odd
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
module vsm_vector_and_stack_map
  import vsm_pkg::*;
#(
  parameter bit LARGE = 1'b1,
  parameter logic [15:0] RESET_VECTOR = 16'hE000,
  parameter logic [7:0] MONITOR_FILL = 8'h00,
  parameter int WDOG_BITS = 12
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire vsm_wb_req_t wbReq,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  input wire vsm_req_t cpuReq,
  input wire logic cpuValid,
  output logic cpuReady,
  output vsm_resp_t cpuResp,
  output logic cpuDone,
  output logic [15:0] stackPtr,
  output logic wdogExpired
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_PUSH, ST_PULL, ST_PULLW, ST_VHI, ST_VHIW, ST_VLO, ST_VLOW
  } vsm_state_t;
  typedef enum logic [2:0] {
    RD_NONE, RD_RAM, RD_VEC, RD_RSTLO, RD_SPH, RD_SPL, RD_STAT, RD_MON
  } vsm_rdsel_t;

  vsm_state_t state_reg, state_next;
  vsm_rdsel_t rdSel_reg;
  logic [15:0] sp_reg, sp_next;
  logic [39:0] pushBuf_reg, pullBuf_reg;
  logic [2:0] cnt_reg;
  logic doVec_reg;
  vsm_vec_t vec_reg;
  logic [7:0] pcHi_reg;
  logic wbPend_reg, ack_reg, done_reg;
  vsm_resp_t resp_reg;
  logic [WDOG_BITS-1:0] wdog_reg;
  logic wdogExp_reg;

  // bus address and take
  wire [15:0] wbAddr = wbReq.adr[17:2];
  wire wbTake = wbReq.cyc && wbReq.stb && !wbPend_reg && !ack_reg &&
                state_reg == ST_IDLE;
  wire wbWrite = wbPend_reg && wbReq.we && wbReq.sel[0];
  wire [7:0] wbByte = wbReq.dat[7:0];
  wire cmdTake = cpuValid && cpuReady;

  // shared memory port
  wire [15:0] vecHiAddr = vsm_vec_addr(vec_reg); // [RULE9] [RULE10]
  logic [15:0] memAddr;
  logic memWe;
  logic [7:0] memWdata;
  always_comb begin
    memAddr = wbAddr;
    memWe = wbWrite;
    memWdata = wbByte;
    case (state_reg)
      ST_PUSH: begin
        memAddr = sp_reg;
        memWe = 1'b1;
        memWdata = pushBuf_reg[39:32];
      end
      ST_PULL: begin
        memAddr = sp_reg + 16'h0001;
        memWe = 1'b0;
      end
      ST_VHI: begin
        memAddr = vecHiAddr; // [RULE16] [RULE11] [RULE12] [RULE13]
        memWe = 1'b0;
      end
      ST_VLO: begin
        memAddr = vecHiAddr + 16'h0001; // [RULE16]
        memWe = 1'b0;
      end
      default: begin
      end
    endcase
  end

  // address decode
  wire [15:0] ramEnd = LARGE ? RAM_END_LARGE : RAM_END_SMALL;
  wire [15:0] monEnd = LARGE ? MON_END_LARGE : MON_END_SMALL;
  wire ramHit = vsm_in_range(memAddr, RAM_START, ramEnd); // [RULE7] [RULE8]
  wire monHit = vsm_in_range(memAddr, MON_START, monEnd); // [RULE15]
  wire wdogHit = memAddr == WDOG_CLEAR_ADDR; // [RULE14]
  wire vecHit = vsm_in_range(memAddr, VEC_BASE, WDOG_CLEAR_ADDR - 16'h0001);
  wire spHiHit = memAddr == SP_HI_ADDR;
  wire spLoHit = memAddr == SP_LO_ADDR;
  wire statHit = memAddr == STATUS_ADDR;
  wire [15:0] ramOff = memAddr - RAM_START;
  wire [15:0] vecOff = memAddr - VEC_BASE;
  wire [7:0] ramRd, vecRd;

  vsm_mem #(.DEPTH(256), .AW(8)) ramMem (
    .sys_clk(sys_clk),
    .rst(rst),
    .we(memWe && ramHit),
    .addr(ramOff[7:0]),
    .wdata(memWdata),
    .rdata(ramRd)
  );

  vsm_mem #(.DEPTH(46), .AW(6)) vecMem (
    .sys_clk(sys_clk),
    .rst(rst),
    .we(wbWrite && vecHit),
    .addr(vecOff[5:0]),
    .wdata(memWdata),
    .rdata(vecRd)
  );

  vsm_rdsel_t rdSelNext;
  assign rdSelNext = ramHit ? RD_RAM :
                     vecHit ? RD_VEC :
                     wdogHit ? RD_RSTLO :
                     monHit ? RD_MON :
                     spHiHit ? RD_SPH :
                     spLoHit ? RD_SPL :
                     statHit ? RD_STAT : RD_NONE;

  wire [7:0] statusByte = {(state_reg != ST_IDLE), 2'b00, 5'(vec_reg)};
  logic [7:0] rdByte;
  always_comb begin
    case (rdSel_reg)
      RD_RAM: rdByte = ramRd;
      RD_VEC: rdByte = vecRd;
      RD_RSTLO: rdByte = RESET_VECTOR[7:0]; // [RULE14]
      RD_MON: rdByte = MONITOR_FILL;
      RD_SPH: rdByte = sp_reg[15:8];
      RD_SPL: rdByte = sp_reg[7:0];
      RD_STAT: rdByte = statusByte;
      default: rdByte = 8'h00;
    endcase
  end

  assign cpuReady = state_reg == ST_IDLE && !wbPend_reg && !ack_reg &&
                    !wbTake;
  assign wbAck = ack_reg;
  assign wbDatOut = ack_reg ? {24'h000000, rdByte} : 32'h00000000;
  assign cpuResp = resp_reg;
  assign cpuDone = done_reg;
  assign stackPtr = sp_reg;
  assign wdogExpired = wdogExp_reg;

  // sequencer
  wire lastByte = cnt_reg == ONE_BYTE;
  wire [2:0] cntDec = cnt_reg - 3'h1;
  always_comb begin
    state_next = state_reg;
    sp_next = sp_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cmdTake) begin
          case (cpuReq.cmd)
            CMD_PUSH, CMD_CALL, CMD_INTERRUPT: state_next = ST_PUSH;
            CMD_PULL, CMD_RETURN, CMD_RTI: state_next = ST_PULL;
            default: state_next = ST_VHI;
          endcase
        end else if (wbWrite && spHiHit) begin
          sp_next = {wbByte, sp_reg[7:0]};
        end else if (wbWrite && spLoHit) begin
          sp_next = {sp_reg[15:8], wbByte};
        end
      end
      ST_PUSH: begin
        sp_next = sp_reg - 16'h0001; // [RULE1]
        if (lastByte) begin
          state_next = doVec_reg ? ST_VHI : ST_IDLE;
        end
      end
      ST_PULL: begin
        sp_next = sp_reg + 16'h0001; // [RULE1]
        state_next = ST_PULLW;
      end
      ST_PULLW: state_next = lastByte ? ST_IDLE : ST_PULL;
      ST_VHI: state_next = ST_VHIW;
      ST_VHIW: state_next = ST_VLO;
      ST_VLO: state_next = ST_VLOW;
      default: state_next = ST_IDLE;
    endcase
  end

  // stacked byte count per command, high index never included
  logic [2:0] loadCnt;
  logic [39:0] loadBuf;
  always_comb begin
    loadBuf = 40'h0000000000;
    case (cpuReq.cmd)
      CMD_PUSH, CMD_PULL: loadCnt = ONE_BYTE;
      CMD_CALL, CMD_RETURN: loadCnt = CALL_BYTES; // [RULE4]
      CMD_INTERRUPT, CMD_RTI: loadCnt = INTR_BYTES; // [RULE2]
      default: loadCnt = 3'h0;
    endcase
    case (cpuReq.cmd)
      CMD_PUSH: loadBuf = {cpuReq.data, 32'h00000000};
      CMD_CALL: loadBuf = {cpuReq.pc[7:0], cpuReq.pc[15:8], 24'h000000};
      CMD_INTERRUPT: loadBuf = {cpuReq.pc[7:0], cpuReq.pc[15:8], cpuReq.x,
                                cpuReq.a, cpuReq.ccr}; // [RULE3]
      default: loadBuf = 40'h0000000000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      sp_reg <= SP_RESET; // [RULE5] [RULE6]
    end else begin
      state_reg <= state_next;
      sp_reg <= sp_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 3'h0;
      pushBuf_reg <= 40'h0000000000;
      pullBuf_reg <= 40'h0000000000;
      doVec_reg <= 1'b0;
      vec_reg <= SRC_RESET;
    end else if (cmdTake) begin
      cnt_reg <= loadCnt;
      pushBuf_reg <= loadBuf;
      pullBuf_reg <= 40'h0000000000;
      doVec_reg <= cpuReq.cmd == CMD_INTERRUPT || cpuReq.cmd == CMD_FETCH;
      vec_reg <= cpuReq.vec;
    end else if (state_reg == ST_PUSH) begin
      cnt_reg <= cntDec;
      pushBuf_reg <= {pushBuf_reg[31:0], 8'h00};
    end else if (state_reg == ST_PULLW) begin
      cnt_reg <= cntDec;
      pullBuf_reg <= {pullBuf_reg[31:0], rdByte};
    end
  end

  // vector fetch and completion
  wire finishing = (state_reg == ST_VLOW) ||
                   (state_reg == ST_PULLW && lastByte) ||
                   (state_reg == ST_PUSH && lastByte && !doVec_reg);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pcHi_reg <= 8'h00;
      done_reg <= 1'b0;
      resp_reg <= '0;
    end else begin
      done_reg <= finishing;
      if (state_reg == ST_VHIW) begin
        pcHi_reg <= rdByte; // [RULE16]
      end
      if (state_reg == ST_VLOW) begin
        resp_reg.newPc <= {pcHi_reg, rdByte}; // [RULE16]
      end
      if (state_reg == ST_PULLW) begin
        resp_reg.pulled <= {pullBuf_reg[31:0], rdByte};
      end
    end
  end

  // bus slave and read select
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wbPend_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdSel_reg <= RD_NONE;
    end else begin
      wbPend_reg <= wbTake;
      ack_reg <= wbPend_reg;
      rdSel_reg <= rdSelNext;
    end
  end

  // watchdog counter, cleared by a write with sel[0] set to the reset vector low byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wdog_reg <= '0;
      wdogExp_reg <= 1'b0;
    end else begin
      wdogExp_reg <= &wdog_reg;
      wdog_reg <= (wbWrite && wdogHit) ? '0 : wdog_reg + 1'b1; // [RULE14]
    end
  end

  a_sp_reset_value: assert property (@(posedge sys_clk) // [RULE5]
    $fell(rst) |-> sp_reg == SP_RESET)
    else $error("stack pointer not at reset location");
  a_push_sp_dec: assert property (@(posedge sys_clk) // [RULE1]
    disable iff (rst) state_reg == ST_PUSH |=> sp_reg == $past(sp_reg) - 1)
    else $error("push did not decrement stack pointer");
  a_pull_sp_inc: assert property (@(posedge sys_clk) // [RULE1]
    disable iff (rst) state_reg == ST_PULL |=> sp_reg == $past(sp_reg) + 1)
    else $error("pull did not increment stack pointer");
  a_intr_five_bytes: assert property (@(posedge sys_clk) // [RULE2]
    disable iff (rst) cmdTake && cpuReq.cmd == CMD_INTERRUPT |=>
      (state_reg == ST_PUSH) [*5] ##1 state_reg == ST_VHI)
    else $error("interrupt entry did not stack five bytes");
  a_intr_no_high: assert property (@(posedge sys_clk) // [RULE3]
    disable iff (rst) cmdTake && cpuReq.cmd == CMD_INTERRUPT |=>
      ##2 memWdata == $past(cpuReq.x, 3) ##1 memWdata == $past(cpuReq.a, 4))
    else $error("index and accumulator not stacked in order");
  a_call_two_bytes: assert property (@(posedge sys_clk) // [RULE4]
    disable iff (rst) cmdTake && cpuReq.cmd == CMD_CALL |=>
      (state_reg == ST_PUSH) [*2] ##1 state_reg == ST_IDLE)
    else $error("call did not stack two bytes");
  a_vec_even_odd: assert property (@(posedge sys_clk) // [RULE16]
    disable iff (rst) state_reg == ST_VHI |-> !memAddr[0] ##2
      state_reg == ST_VLO && memAddr == $past(memAddr, 2) + 1)
    else $error("vector fetch order wrong");
  a_reset_low_read: assert property (@(posedge sys_clk) // [RULE14]
    disable iff (rst) wbPend_reg && !wbReq.we && wdogHit |=>
      wbAck && wbDatOut[7:0] == RESET_VECTOR[7:0])
    else $error("reset vector low byte not returned");
  a_wdog_clear: assert property (@(posedge sys_clk) // [RULE14]
    disable iff (rst) wbWrite && wdogHit |=> wdog_reg == '0)
    else $error("watchdog not cleared");
  a_ram_window: assert property (@(posedge sys_clk) // [RULE7]
    disable iff (rst) (memAddr == RAM_START || memAddr == ramEnd ||
      memAddr == PAGE0_END) |-> ramHit && !monHit)
    else $error("RAM decode wrong");
  c_interrupt: cover property (@(posedge sys_clk) disable iff (rst)
    cmdTake && cpuReq.cmd == CMD_INTERRUPT ##10 cpuDone);
  c_rti: cover property (@(posedge sys_clk) disable iff (rst)
    cmdTake && cpuReq.cmd == CMD_RTI);
  c_wdog_write: cover property (@(posedge sys_clk) disable iff (rst)
    wbWrite && wdogHit);
  c_mon_read: cover property (@(posedge sys_clk) disable iff (rst)
    wbPend_reg && monHit);
endmodule

// ---- vsm_pkg.sv ----
package vsm_pkg;

  // memory map
  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [15:0] RAM_START = 16'h0060;
  localparam logic [15:0] RAM_END_SMALL = 16'h011F;
  localparam logic [15:0] RAM_END_LARGE = 16'h015F;
  localparam logic [15:0] PAGE0_END = 16'h00FF;
  localparam int PAGE0_RAM_BYTES = 160;
  localparam logic [15:0] MON_START = 16'hFE10;
  localparam logic [15:0] MON_END_SMALL = 16'hFF20;
  localparam logic [15:0] MON_END_LARGE = 16'hFF48;
  localparam logic [15:0] VEC_BASE = 16'hFFD2;
  localparam logic [15:0] WDOG_CLEAR_ADDR = 16'hFFFF;
  localparam logic [15:0] SP_HI_ADDR = 16'hFE00;
  localparam logic [15:0] SP_LO_ADDR = 16'hFE01;
  localparam logic [15:0] STATUS_ADDR = 16'hFE02;
  localparam int STATUS_BUSY_BIT = 7;

  // stacking byte counts
  localparam logic [2:0] INTR_BYTES = 3'h5;
  localparam logic [2:0] CALL_BYTES = 3'h2;
  localparam logic [2:0] ONE_BYTE = 3'h1;

  // vector high-byte addresses
  localparam logic [15:0] VEC_SERIAL_COMM_TX = 16'hFFD2;
  localparam logic [15:0] VEC_SERIAL_COMM_RX = 16'hFFD4;
  localparam logic [15:0] VEC_SERIAL_COMM_ERR = 16'hFFD6;
  localparam logic [15:0] VEC_CONVERTER = 16'hFFDC;
  localparam logic [15:0] VEC_TIMER_B_OVF = 16'hFFDE;
  localparam logic [15:0] VEC_TIMER_B_CH1 = 16'hFFE0;
  localparam logic [15:0] VEC_TIMER_B_CH0 = 16'hFFE2;
  localparam logic [15:0] VEC_TIMER_A_OVF = 16'hFFE4;
  localparam logic [15:0] VEC_TIMER_A_CH1 = 16'hFFEA;
  localparam logic [15:0] VEC_TIMER_A_CH0 = 16'hFFEC;
  localparam logic [15:0] VEC_MOTOR_PWM = 16'hFFEE;
  localparam logic [15:0] VEC_FAULT4 = 16'hFFF0;
  localparam logic [15:0] VEC_FAULT1 = 16'hFFF6;
  localparam logic [15:0] VEC_CLOCK_SYNTH = 16'hFFF8;
  localparam logic [15:0] VEC_EXT_IRQ = 16'hFFFA;
  localparam logic [15:0] VEC_SOFTWARE_INTERRUPT = 16'hFFFC;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;

  typedef enum logic [4:0] {
    SRC_SERIAL_COMM_TX, SRC_SERIAL_COMM_RX, SRC_SERIAL_COMM_ERR,
    SRC_CONVERTER, SRC_TIMER_B_OVF, SRC_TIMER_B_CH1, SRC_TIMER_B_CH0,
    SRC_TIMER_A_OVF, SRC_TIMER_A_CH1, SRC_TIMER_A_CH0, SRC_MOTOR_PWM,
    SRC_FAULT4, SRC_FAULT1, SRC_CLOCK_SYNTH, SRC_EXT_IRQ,
    SRC_SOFTWARE_INTERRUPT, SRC_RESET
  } vsm_vec_t;

  typedef enum logic [2:0] {
    CMD_PUSH, CMD_PULL, CMD_CALL, CMD_RETURN, CMD_INTERRUPT, CMD_RTI,
    CMD_FETCH
  } vsm_cmd_t;

  typedef struct packed {
    vsm_cmd_t cmd;
    vsm_vec_t vec;
    logic [15:0] pc;
    logic [7:0] x;
    logic [7:0] a;
    logic [7:0] ccr;
    logic [7:0] data;
  } vsm_req_t;

  typedef struct packed {
    logic [39:0] pulled;
    logic [15:0] newPc;
  } vsm_resp_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [17:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } vsm_wb_req_t;

  function automatic logic [15:0] vsm_vec_addr(input vsm_vec_t v);
    case (v)
      SRC_SERIAL_COMM_TX: vsm_vec_addr = VEC_SERIAL_COMM_TX;
      SRC_SERIAL_COMM_RX: vsm_vec_addr = VEC_SERIAL_COMM_RX;
      SRC_SERIAL_COMM_ERR: vsm_vec_addr = VEC_SERIAL_COMM_ERR;
      SRC_CONVERTER: vsm_vec_addr = VEC_CONVERTER;
      SRC_TIMER_B_OVF: vsm_vec_addr = VEC_TIMER_B_OVF;
      SRC_TIMER_B_CH1: vsm_vec_addr = VEC_TIMER_B_CH1;
      SRC_TIMER_B_CH0: vsm_vec_addr = VEC_TIMER_B_CH0;
      SRC_TIMER_A_OVF: vsm_vec_addr = VEC_TIMER_A_OVF;
      SRC_TIMER_A_CH1: vsm_vec_addr = VEC_TIMER_A_CH1;
      SRC_TIMER_A_CH0: vsm_vec_addr = VEC_TIMER_A_CH0;
      SRC_MOTOR_PWM: vsm_vec_addr = VEC_MOTOR_PWM;
      SRC_FAULT4: vsm_vec_addr = VEC_FAULT4;
      SRC_FAULT1: vsm_vec_addr = VEC_FAULT1;
      SRC_CLOCK_SYNTH: vsm_vec_addr = VEC_CLOCK_SYNTH;
      SRC_EXT_IRQ: vsm_vec_addr = VEC_EXT_IRQ;
      SRC_SOFTWARE_INTERRUPT: vsm_vec_addr = VEC_SOFTWARE_INTERRUPT;
      default: vsm_vec_addr = VEC_RESET;
    endcase
  endfunction

  function automatic logic vsm_in_range(input logic [15:0] a,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    vsm_in_range = (a >= lo) && (a <= hi);
  endfunction

endpackage

// ---- vsm_mem.sv ----
`timescale 1ns/1ps
module vsm_mem #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] store [0:DEPTH-1];
  wire inBounds = (int'(addr) < DEPTH);

  always_ff @(posedge sys_clk) begin
    if (we && inBounds) begin
      store[addr] <= wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= inBounds ? store[addr] : 8'h00;
    end
  end
endmodule

// ---- vsm_cpu_model.sv ----
`timescale 1ns/1ps
module vsm_cpu_model
  import vsm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cpuReady,
  input wire logic cpuDone,
  input wire vsm_resp_t cpuResp,
  output vsm_req_t cpuReq,
  output logic cpuValid
);
  initial begin
    cpuReq = '0;
    cpuValid = 1'b0;
  end

  // one command in flight; the next waits for the done pulse
  task automatic run(input vsm_req_t r, output vsm_resp_t resp,
                     output bit ok);
    int n;
    ok = 1'b0;
    @(posedge sys_clk);
    cpuReq <= r;
    cpuValid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge sys_clk);
      if (cpuReady === 1'b1) break;
    end
    cpuValid <= 1'b0;
    // stale request fields must not look valid
    cpuReq <= ~r;
    for (n = 0; n < 100; n++) begin
      @(posedge sys_clk);
      if (cpuDone === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
    resp = cpuResp;
  endtask
endmodule

// ---- vector_and_stack_map_tb.sv ----
`timescale 1ns/1ps
module vector_and_stack_map_tb
  import vsm_pkg::*;
();
  localparam logic [15:0] RV = 16'hC35A;
  localparam logic [7:0] MFILL = 8'hA5;
  logic sys_clk, rst, wbAck, cpuValid, cpuReady, cpuDone, wdogExpired;
  vsm_wb_req_t wbReq;
  vsm_req_t cpuReq, lastReq;
  vsm_resp_t cpuResp, resp;
  logic [31:0] wbDatOut, q;
  logic [15:0] stackPtr, sp, a;
  logic [19:0] lfsrState;
  logic [39:0] e;
  logic [7:0] refMem [int];
  int mismatches, samplesChecked, cycles, wdogPulses, k, j;
  logic [15:0] vecTab [17] = '{16'hFFD2, 16'hFFD4, 16'hFFD6,
    16'hFFDC, 16'hFFDE, 16'hFFE0, 16'hFFE2,
    16'hFFE4, 16'hFFEA, 16'hFFEC,
    16'hFFEE, 16'hFFF0, 16'hFFF6,
    16'hFFF8, 16'hFFFA, 16'hFFFC, 16'hFFFE};

  vsm_vector_and_stack_map #(.LARGE(1'b1), .RESET_VECTOR(RV),
    .MONITOR_FILL(MFILL), .WDOG_BITS(4)) DUT (.sys_clk(sys_clk),
    .rst(rst), .wbReq(wbReq), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .cpuReq(cpuReq), .cpuValid(cpuValid), .cpuReady(cpuReady),
    .cpuResp(cpuResp), .cpuDone(cpuDone), .stackPtr(stackPtr),
    .wdogExpired(wdogExpired));
  vsm_cpu_model cpuModel (.sys_clk(sys_clk), .rst(rst),
    .cpuReady(cpuReady), .cpuDone(cpuDone), .cpuResp(cpuResp),
    .cpuReq(cpuReq), .cpuValid(cpuValid));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (wdogExpired === 1'b1) wdogPulses++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  function automatic logic [7:0] rnd();
    lfsrState = {lfsrState[18:0], lfsrState[19] ^ lfsrState[16]};
    return lfsrState[7:0];
  endfunction

  function automatic logic [7:0] expRd(input logic [15:0] ad);
    if (ad == 16'hFFFF) return RV[7:0];
    if (ad == 16'hFE00) return sp[15:8];
    if (ad == 16'hFE01) return sp[7:0];
    if (ad >= 16'hFE10 && ad <= 16'hFF48) return MFILL;
    if (refMem.exists(ad)) return refMem[ad];
    return 8'h00;
  endfunction

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [15:0] ad,
                    input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    wbReq <= {1'b1, 1'b1, we, ad, 2'b00, 4'hF, 24'h000000, d};
    for (n = 0; n < 100; n++) begin
      @(posedge sys_clk);
      if (wbAck === 1'b1) break;
    end
    q = wbDatOut;
    wbReq <= '0;
  endtask

  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    wb(1'b1, ad, d);
    if (ad == 16'hFE00) sp[15:8] = d;
    else if (ad == 16'hFE01) sp[7:0] = d;
    else if ((ad >= 16'h0060 && ad <= 16'h015F) ||
             (ad >= 16'hFFD2 && ad <= 16'hFFFE)) refMem[ad] = d;
  endtask

  task automatic rdchk(input logic [15:0] ad);
    wb(1'b0, ad, 8'h00);
    check(q, {24'h000000, expRd(ad)});
  endtask

  task automatic cpu(input vsm_cmd_t c, input int v, input logic [7:0] d);
    vsm_req_t r;
    bit ok;
    r.cmd = c;
    r.vec = vsm_vec_t'(v[4:0]);
    r.pc = {rnd(), rnd()};
    r.x = rnd();
    r.a = rnd();
    r.ccr = rnd();
    r.data = d;
    cpuModel.run(r, resp, ok);
    check(40'(ok), 40'd1);
    lastReq = r;
  endtask

  task automatic push(input logic [7:0] b);
    refMem[sp] = b;
    sp = sp - 16'h0001;
  endtask

  function automatic logic [7:0] pull();
    sp = sp + 16'h0001;
    return refMem[sp];
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    wbReq = '0;
    lfsrState = 20'h17D59;
    sp = 16'h00FF;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check(stackPtr, 16'h00FF);
    rdchk(16'hFE00);
    rdchk(16'hFE01);
    $display("reset test done");
    foreach (vecTab[i]) a = vecTab[i];
    for (k = 0; k < 7; k++) begin
      a = k == 0 ? 16'h0060 : k == 1 ? 16'h00FF : k == 2 ? 16'h0100 :
          k == 3 ? 16'h015F : k == 4 ? 16'h0160 : k == 5 ? 16'hFE10 :
          16'hFF48;
      wr(a, rnd());
      rdchk(a);
    end
    $display("memory map test done");
    for (k = 16'hFFD2; k <= 16'hFFFF; k++) wr(k[15:0], rnd());
    for (k = 16'hFFD2; k <= 16'hFFFF; k++) rdchk(k[15:0]);
    $display("vector store test done");
    for (k = 0; k < 17; k++) begin
      cpu(CMD_INTERRUPT, k, 8'h00);
      push(lastReq.pc[7:0]);
      push(lastReq.pc[15:8]);
      push(lastReq.x);
      push(lastReq.a);
      push(lastReq.ccr);
      check(resp.newPc, {expRd(vecTab[k]), expRd(vecTab[k] + 1)});
      check(stackPtr, sp);
      for (j = 1; j <= 5; j++) rdchk(sp + j[15:0]);
      wb(1'b0, 16'hFE02, 8'h00);
      check({q[7], q[4:0]}, {1'b0, k[4:0]});
    end
    a = lastReq.pc;
    cpu(CMD_RTI, 0, 8'h00);
    e = '0;
    for (j = 0; j < 5; j++) e = {e[31:0], pull()};
    check(resp.pulled, e);
    check(resp.pulled[15:0], a);
    check(stackPtr, sp);
    $display("interrupt test done");
    cpu(CMD_CALL, 0, 8'h00);
    push(lastReq.pc[7:0]);
    push(lastReq.pc[15:8]);
    check(stackPtr, sp);
    a = lastReq.pc;
    cpu(CMD_RETURN, 0, 8'h00);
    e[15:8] = pull();
    e[7:0] = pull();
    check(resp.pulled[15:0], a);
    check(stackPtr, sp);
    for (k = 0; k < 3; k++) begin
      cpu(CMD_PUSH, 0, rnd());
      push(lastReq.data);
      check(stackPtr, sp);
    end
    for (k = 0; k < 3; k++) begin
      cpu(CMD_PULL, 0, 8'h00);
      check(resp.pulled[7:0], pull());
      check(stackPtr, sp);
    end
    cpu(CMD_FETCH, 16, 8'h00);
    check(resp.newPc, {expRd(16'hFFFE), RV[7:0]});
    $display("stacking test done");
    wr(16'hFE00, 8'h12);
    wr(16'hFE01, 8'h34);
    check(stackPtr, 16'h1234);
    rdchk(16'hFE00);
    rdchk(16'hFE01);
    wr(16'hFE00, 8'h00);
    wr(16'hFE01, 8'hFF);
    $display("stack pointer test done");
    wdogPulses = 0;
    repeat (40) @(posedge sys_clk);
    check(40'(wdogPulses >= 2), 40'd1);
    wr(16'hFFFF, rnd());
    wdogPulses = 0;
    for (k = 0; k < 12; k++) wr(16'hFFFF, rnd());
    check(wdogPulses, 40'd0);
    rdchk(16'hFFFF);
    $display("watchdog test done");
    summarize();
  end
endmodule
